// ==== inc/dcec_cfg.svh ====
// Offsets, field positions and reset values of the comparator control block.
// Included by the package and the design; definitions only.
`ifndef DCEC_CFG_SVH
`define DCEC_CFG_SVH

// Register byte offsets, one aligned word each
`define DCEC_OFS_CTRL0 8'h00
`define DCEC_OFS_MODE0 8'h04
`define DCEC_OFS_MUX0 8'h08
`define DCEC_OFS_CTRL1 8'h0C
`define DCEC_OFS_MODE1 8'h10
`define DCEC_OFS_MUX1 8'h14

// Control register fields
`define DCEC_CTL_EN 7
`define DCEC_CTL_OUT 6
`define DCEC_CTL_RISE 5
`define DCEC_CTL_FALL 4
`define DCEC_CTL_HYP_LO 2
`define DCEC_CTL_HYN_LO 0

// Mode register fields
`define DCEC_MD_RIE 5
`define DCEC_MD_FIE 4
`define DCEC_MD_RESP_LO 0

// Input select register fields
`define DCEC_MX_NEG_LO 4
`define DCEC_MX_POS_LO 0

// Reset values
`define DCEC_RST_CTRL 8'h00
`define DCEC_RST_MODE 8'h02
`define DCEC_RST_MUX 8'h00

// AXI responses
`define DCEC_RESP_OKAY 2'b00
`define DCEC_RESP_SLVERR 2'b10

`endif

// ==== inc/dcec_pkg.sv ====
// Types shared by the comparator control block.
// Assumes dcec_cfg.svh is on the include path.
`include "dcec_cfg.svh"

package dcec_pkg;

    // Response time: fastest/highest power first
    typedef enum logic [1:0] {
        DCEC_RESP_FAST = 2'b00,
        DCEC_RESP_MID1 = 2'b01,
        DCEC_RESP_MID2 = 2'b10,
        DCEC_RESP_SLOW = 2'b11
    } dcec_resp_t;

    // Hysteresis amount per direction
    typedef enum logic [1:0] {
        DCEC_HYST_OFF = 2'b00,
        DCEC_HYST_5MV = 2'b01,
        DCEC_HYST_10MV = 2'b10,
        DCEC_HYST_20MV = 2'b11
    } dcec_hyst_t;

    // Settings driven to one analog comparator
    typedef struct packed {
        logic power_on;
        dcec_resp_t response_mode;
        dcec_hyst_t pos_hyst;
        dcec_hyst_t neg_hyst;
        logic [1:0] pos_input_sel;
        logic [1:0] neg_input_sel;
    } dcec_analog_cfg_t;

endpackage : dcec_pkg

// ==== rtl/dcec_top.sv ====
// Control and status logic for two voltage comparators, AXI4-Lite slave.
// Assumes the analog decisions arrive as levels and are sampled on aclk.
//
// What this block does
// - Two identical channels; channel 0 also resets
// - Latched and raw outputs per comparator
// - Raw output needs no clock
// - Separate positive and negative input select fields
// - Result readable, interrupting and routable together
// - Disabled comparator: raw, latched and reset outputs low, power off
// - Mode field picks response time and current
// - Independent positive and negative hysteresis fields
// - Falling output sets fall flag
// - Rising output sets rise flag
// - Flags sticky; software writes 0 to clear
// - Interrupt on rise, fall or both
// - Output state bit read-only, no side effect
// - Enable bit turns comparator on/off
// - Mode bits 5/4 gate rise/fall interrupts
// - Response mode 00 fastest, 11 slowest
// - Hysteresis 00 off, then 5, 10, 20 mV
// - Control bits 7..4: enable, output, rise, fall
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dcec_cfg.svh"

module dcec_top
    import dcec_pkg::*;
#(
    parameter int NUM_CMP = 2
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cmp0_decision,
    input wire logic cmp1_decision,
    output dcec_analog_cfg_t cmp0_analog_cfg,
    output dcec_analog_cfg_t cmp1_analog_cfg,
    output logic cmp0_latched_out,
    output logic cmp1_latched_out,
    output logic cmp0_raw_out,
    output logic cmp1_raw_out,
    output logic cmp0_irq,
    output logic cmp1_irq,
    output logic cmp0_reset_req
);

    if (NUM_CMP != 2) begin : g_bad_num
        $error("dcec_top serves exactly two comparators");
    end

    // Software-owned fields
    logic [1:0] en_ff, rise_ff, fall_ff, rie_ff, fie_ff;
    logic [1:0] nxt_rise, nxt_fall;
    logic [1:0] hyp_ff [2];
    logic [1:0] hyn_ff [2];
    logic [1:0] resp_ff [2];
    logic [1:0] psel_ff [2];
    logic [1:0] nsel_ff [2];
    // Two-stage sampling of the decisions, then one-cycle history
    logic [1:0] sync1_ff, sync2_ff, prev_ff;
    logic [1:0] lat_ff, irq_ff;
    logic rst_req_ff;

    // Raw decisions gated to low while disabled; no clock in this path
    logic [1:0] raw_dec;
    assign raw_dec = {cmp1_decision, cmp0_decision};
    assign cmp0_raw_out = raw_dec[0] & en_ff[0];
    assign cmp1_raw_out = raw_dec[1] & en_ff[1];

    // Write channel: take address and data in either order
    logic aw_ff, w_ff, bvalid_ff;
    logic [7:0] awaddr_ff;
    logic [7:0] wbyte_ff;
    logic wstrb0_ff;
    wire do_write = aw_ff & w_ff & ~bvalid_ff;
    wire wr_en = do_write & wstrb0_ff;
    wire [2:0] wr_reg = 3'(awaddr_ff[4:2]);
    wire wr_ctl0 = wr_en && (awaddr_ff == `DCEC_OFS_CTRL0);
    wire wr_md0 = wr_en && (awaddr_ff == `DCEC_OFS_MODE0);
    wire wr_mx0 = wr_en && (awaddr_ff == `DCEC_OFS_MUX0);
    wire wr_ctl1 = wr_en && (awaddr_ff == `DCEC_OFS_CTRL1);
    wire wr_md1 = wr_en && (awaddr_ff == `DCEC_OFS_MODE1);
    wire wr_mx1 = wr_en && (awaddr_ff == `DCEC_OFS_MUX1);
    wire [1:0] wr_ctl = {wr_ctl1, wr_ctl0};
    wire [1:0] wr_md = {wr_md1, wr_md0};
    wire [1:0] wr_mx = {wr_mx1, wr_mx0};
    // Upper address bits must be zero too, or aliases would answer OKAY
    wire wr_hit = (awaddr_ff[7:5] == 3'h0) && (awaddr_ff[1:0] == 2'b00)
        && (wr_reg < 3'h6);

    assign s_axi_awready = ~aw_ff;
    assign s_axi_wready = ~w_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wbyte_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
            s_axi_bresp <= `DCEC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !aw_ff)
            begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_ff)
            begin
                w_ff <= 1'b1;
                wbyte_ff <= s_axi_wdata[7:0];
                wstrb0_ff <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                bvalid_ff <= 1'b1;
                s_axi_bresp <= wr_hit ? `DCEC_RESP_OKAY : `DCEC_RESP_SLVERR;
            end
            if (bvalid_ff && s_axi_bready)
            begin
                bvalid_ff <= 1'b0;
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_ff;

    // Per-channel registers and edge flags
    for (genvar i = 0; i < 2; i++) begin : g_ch
        wire rise_ev = sync2_ff[i] & ~prev_ff[i];
        wire fall_ev = ~sync2_ff[i] & prev_ff[i];
        wire clr_rise = wr_ctl[i] & ~wbyte_ff[`DCEC_CTL_RISE];
        wire clr_fall = wr_ctl[i] & ~wbyte_ff[`DCEC_CTL_FALL];
        // Writing 1 leaves a flag alone; only hardware sets it
        assign nxt_rise[i] = rise_ev | (rise_ff[i] & ~clr_rise);
        assign nxt_fall[i] = fall_ev | (fall_ff[i] & ~clr_fall);

        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                en_ff[i] <= 1'b0;
                hyp_ff[i] <= 2'b00;
                hyn_ff[i] <= 2'b00;
                rie_ff[i] <= 1'b0;
                fie_ff[i] <= 1'b0;
                resp_ff[i] <= 2'(`DCEC_RST_MODE);
                psel_ff[i] <= 2'b00;
                nsel_ff[i] <= 2'b00;
                rise_ff[i] <= 1'b0;
                fall_ff[i] <= 1'b0;
            end
            else
            begin
                rise_ff[i] <= nxt_rise[i];
                fall_ff[i] <= nxt_fall[i];
                if (wr_ctl[i])
                begin
                    en_ff[i] <= wbyte_ff[`DCEC_CTL_EN];
                    hyp_ff[i] <= wbyte_ff[`DCEC_CTL_HYP_LO +: 2];
                    hyn_ff[i] <= wbyte_ff[`DCEC_CTL_HYN_LO +: 2];
                end
                if (wr_md[i])
                begin
                    rie_ff[i] <= wbyte_ff[`DCEC_MD_RIE];
                    fie_ff[i] <= wbyte_ff[`DCEC_MD_FIE];
                    resp_ff[i] <= wbyte_ff[`DCEC_MD_RESP_LO +: 2];
                end
                if (wr_mx[i])
                begin
                    psel_ff[i] <= wbyte_ff[`DCEC_MX_POS_LO +: 2];
                    nsel_ff[i] <= wbyte_ff[`DCEC_MX_NEG_LO +: 2];
                end
            end
        end
    end

    // Sampling, latched outputs, interrupt requests
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_ff <= 2'b00;
            sync2_ff <= 2'b00;
            prev_ff <= 2'b00;
            lat_ff <= 2'b00;
            irq_ff <= 2'b00;
            rst_req_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= raw_dec & en_ff;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
            lat_ff <= sync2_ff & en_ff;
            irq_ff <= (nxt_rise & rie_ff) | (nxt_fall & fie_ff);
            // Reset routing is qualified outside; we only present the level
            rst_req_ff <= en_ff[0] & ~sync2_ff[0];
        end
    end
    assign cmp0_latched_out = lat_ff[0];
    assign cmp1_latched_out = lat_ff[1];
    assign cmp0_irq = irq_ff[0];
    assign cmp1_irq = irq_ff[1];
    assign cmp0_reset_req = rst_req_ff;

    // Analog settings; response codes pass straight to the bias logic
    assign cmp0_analog_cfg = '{en_ff[0], dcec_resp_t'(resp_ff[0]),
        dcec_hyst_t'(hyp_ff[0]), dcec_hyst_t'(hyn_ff[0]),
        psel_ff[0], nsel_ff[0]};
    assign cmp1_analog_cfg = '{en_ff[1], dcec_resp_t'(resp_ff[1]),
        dcec_hyst_t'(hyp_ff[1]), dcec_hyst_t'(hyn_ff[1]),
        psel_ff[1], nsel_ff[1]};

    // Read channel: one-cycle answer; reads never touch flags
    wire [2:0] rd_reg = 3'(s_axi_araddr[4:2]);
    wire rd_hit = (s_axi_araddr[7:5] == 3'h0)
        && (s_axi_araddr[1:0] == 2'b00) && (rd_reg < 3'h6);
    wire rd_ch = (rd_reg >= 3'h3);
    wire [1:0] rd_kind = 2'(rd_ch ? rd_reg - 3'h3 : rd_reg);
    wire rc = rd_ch;
    wire [7:0] rd_ctl = {en_ff[rc], lat_ff[rc], rise_ff[rc], fall_ff[rc],
        hyp_ff[rc], hyn_ff[rc]};
    wire [7:0] rd_md = {2'b00, rie_ff[rc], fie_ff[rc], 2'b00, resp_ff[rc]};
    wire [7:0] rd_mx = {2'b00, nsel_ff[rc], 2'b00, psel_ff[rc]};
    wire [7:0] rd_byte = (rd_kind == 2'd0) ? rd_ctl :
        (rd_kind == 2'd1) ? rd_md : rd_mx;
    logic rvalid_ff;
    assign s_axi_arready = ~rvalid_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DCEC_RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_ff)
        begin
            rvalid_ff <= 1'b1;
            s_axi_rdata <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            s_axi_rresp <= rd_hit ? `DCEC_RESP_OKAY : `DCEC_RESP_SLVERR;
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_ff;

    // Checks; edge events are named once so the properties read alike
    sequence s_rise0;
        sync2_ff[0] && !prev_ff[0];
    endsequence
    sequence s_fall1;
        !sync2_ff[1] && prev_ff[1];
    endsequence

    a_rise_sets_flag: assert property (@(posedge aclk)
        disable iff (!aresetn) s_rise0 |=> rise_ff[0])
        else $error("rise edge did not set flag");
    a_fall_sets_flag: assert property (@(posedge aclk)
        disable iff (!aresetn) s_fall1 |=> fall_ff[1])
        else $error("fall edge did not set flag");
    a_flag_sticky: assert property (@(posedge aclk)
        disable iff (!aresetn) (rise_ff[0] && !wr_ctl[0]) |=> rise_ff[0])
        else $error("rise flag dropped without clear");
    // Clear and edge in one cycle: the set must win
    a_set_beats_clear: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (wr_ctl[1] && !fall_ff[1]) ##0 s_fall1 |=> fall_ff[1])
        else $error("clear won over set");
    // Pin and power low at once, latched output low one edge later
    a_disabled_low: assert property (@(posedge aclk)
        disable iff (!aresetn) !en_ff[0] |->
        (!cmp0_raw_out && !cmp0_analog_cfg.power_on) ##1 !cmp0_latched_out)
        else $error("disabled comparator drives high");
    a_irq_gated: assert property (@(posedge aclk)
        disable iff (!aresetn) (!rie_ff[0] && !fie_ff[0]) |=> !cmp0_irq)
        else $error("interrupt without enable");
    a_irq_follows: assert property (@(posedge aclk)
        disable iff (!aresetn) (nxt_rise[1] && rie_ff[1]) |=> cmp1_irq)
        else $error("rise interrupt missing");
    a_enable_write: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_ctl0 |=> en_ff[0] == $past(wbyte_ff[`DCEC_CTL_EN]))
        else $error("enable not written");
    // A flag may only rise after a seen edge, never on its own
    a_edge_once: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $rose(rise_ff[0]) |-> $past(sync2_ff[0]) && !$past(prev_ff[0]))
        else $error("rise flag set without an edge");

endmodule : dcec_top
`default_nettype wire

// ==== bench/dcec_tb_top.sv ====
// Self-checking bench for the comparator control block.
// Assumes dcec_pkg and dcec_top are compiled first; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "dcec_cfg.svh"

module dcec_tb_top
    import dcec_pkg::*;
;
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
        logic [3:0] strb;
        logic [7:0] exp;
        logic [1:0] resp;
    } dcec_row_t;

    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, cmp0_reset_req;
    logic cmp0_decision, cmp1_decision, cmp0_latched_out, cmp1_latched_out;
    logic cmp0_raw_out, cmp1_raw_out, cmp0_irq, cmp1_irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    dcec_analog_cfg_t cmp0_analog_cfg, cmp1_analog_cfg;
    int mismatches, n_checks;
    dcec_row_t rows[19];

    dcec_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp0_decision,
        .cmp1_decision, .cmp0_analog_cfg, .cmp1_analog_cfg,
        .cmp0_latched_out, .cmp1_latched_out, .cmp0_raw_out,
        .cmp1_raw_out, .cmp0_irq, .cmp1_irq, .cmp0_reset_req);

    // Free-running 100 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic wrap_up;
        if (mismatches == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask : check

    // A stuck handshake ends the run instead of hanging it
    task automatic hang;
        mismatches++;
        $display("ERROR %0t: bus handshake timed out", $time);
        wrap_up();
    endtask : hang

    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 50);
        if (!s_axi_bvalid)
            hang();
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 50);
        if (!s_axi_rvalid)
            hang();
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        check(rdat, {24'h00_0000, e});
    endtask : rd_chk

    task automatic set_dec(input int ch, input logic v);
        @(posedge aclk);
        if (ch == 0)
            cmp0_decision <= v;
        else
            cmp1_decision <= v;
    endtask : set_dec

    task automatic settle(input int k);
        repeat (k) @(posedge aclk);
        #1;
    endtask : settle

    // Pin view: reset request, raw, latched, irq, power; channel 1 has
    // no reset request, so that bit is masked there
    task automatic chk_o(input int ch, input logic [4:0] e);
        logic [4:0] o;
        o = (ch == 0) ? {cmp0_reset_req, cmp0_raw_out, cmp0_latched_out,
            cmp0_irq, cmp0_analog_cfg.power_on} : {1'b0, cmp1_raw_out,
            cmp1_latched_out, cmp1_irq, cmp1_analog_cfg.power_on};
        check(32'(o), 32'((ch == 0) ? e : (e & 5'h0F)));
    endtask : chk_o

    // Edge flags, interrupt gating and disable, same for both channels
    task automatic edge_run(input int ch);
        logic [7:0] b;
        b = (ch == 0) ? `DCEC_OFS_CTRL0 : `DCEC_OFS_CTRL1;
        wr(b + 8'h04, 8'h30, 4'hF);
        wr(b, 8'h80, 4'hF);
        wr(b, 8'h80, 4'hF);
        rd_chk(b, 8'h80);
        chk_o(ch, 5'h11);
        set_dec(ch, 1'b1);
        #1;
        chk_o(ch, 5'h19);
        settle(5);
        chk_o(ch, 5'h0F);
        rd_chk(b, 8'hE0);
        wr(b, 8'h90, 4'hF);
        rd_chk(b, 8'hC0);
        settle(2);
        chk_o(ch, 5'h0D);
        set_dec(ch, 1'b0);
        settle(5);
        rd_chk(b, 8'h90);
        chk_o(ch, 5'h13);
        wr(b + 8'h04, 8'h20, 4'hF);
        settle(2);
        chk_o(ch, 5'h11);
        wr(b + 8'h04, 8'h10, 4'hF);
        settle(2);
        chk_o(ch, 5'h13);
        set_dec(ch, 1'b1);
        settle(1);
        set_dec(ch, 1'b0);
        settle(5);
        rd_chk(b, 8'hB0);
        wr(b, 8'hB0, 4'hF);
        rd_chk(b, 8'hB0);
        wr(b, 8'h80, 4'hF);
        rd_chk(b, 8'h80);
        // Fall edge lands on the clearing write: the flag must survive
        set_dec(ch, 1'b1);
        settle(5);
        wr(b, 8'h80, 4'hF);
        set_dec(ch, 1'b0);
        wr(b, 8'h80, 4'hF);
        rd_chk(b, 8'h90);
        wr(b, 8'h80, 4'hF);
        wr(b + 8'h04, 8'h00, 4'hF);
        set_dec(ch, 1'b1);
        settle(5);
        wr(b, 8'h00, 4'hF);
        settle(5);
        chk_o(ch, 5'h00);
        set_dec(ch, 1'b0);
        wr(b, 8'h00, 4'hF);
    endtask : edge_run

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, cmp0_decision, cmp1_decision} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0_0000;
        s_axi_wdata = 32'h0000_0000;
        rows = '{
            '{8'h00, 1'b0, 8'h00, 4'hF, 8'h00, `DCEC_RESP_OKAY},
            '{8'h04, 1'b0, 8'h00, 4'hF, 8'h02, `DCEC_RESP_OKAY},
            '{8'h08, 1'b0, 8'h00, 4'hF, 8'h00, `DCEC_RESP_OKAY},
            '{8'h0C, 1'b0, 8'h00, 4'hF, 8'h00, `DCEC_RESP_OKAY},
            '{8'h10, 1'b0, 8'h00, 4'hF, 8'h02, `DCEC_RESP_OKAY},
            '{8'h14, 1'b0, 8'h00, 4'hF, 8'h00, `DCEC_RESP_OKAY},
            '{8'h08, 1'b1, 8'h33, 4'hF, 8'h33, `DCEC_RESP_OKAY},
            '{8'h08, 1'b1, 8'h11, 4'h0, 8'h33, `DCEC_RESP_OKAY},
            '{8'h14, 1'b1, 8'hFF, 4'hF, 8'h33, `DCEC_RESP_OKAY},
            '{8'h04, 1'b1, 8'hFF, 4'hF, 8'h33, `DCEC_RESP_OKAY},
            '{8'h10, 1'b1, 8'h00, 4'hF, 8'h00, `DCEC_RESP_OKAY},
            '{8'h10, 1'b1, 8'h01, 4'hF, 8'h01, `DCEC_RESP_OKAY},
            '{8'h10, 1'b1, 8'h03, 4'hF, 8'h03, `DCEC_RESP_OKAY},
            '{8'h0C, 1'b1, 8'h45, 4'hF, 8'h05, `DCEC_RESP_OKAY},
            '{8'h0C, 1'b1, 8'h0A, 4'hF, 8'h0A, `DCEC_RESP_OKAY},
            '{8'h0C, 1'b1, 8'h0F, 4'hF, 8'h0F, `DCEC_RESP_OKAY},
            '{8'h18, 1'b1, 8'h55, 4'hF, 8'h00, `DCEC_RESP_SLVERR},
            '{8'h02, 1'b0, 8'h00, 4'hF, 8'h00, `DCEC_RESP_SLVERR},
            '{8'h20, 1'b1, 8'h80, 4'hF, 8'h00, `DCEC_RESP_SLVERR}};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        // Register table: reset values, field masks, read-only bits
        foreach (rows[i])
        begin
            if (rows[i].wr)
            begin
                wr(rows[i].addr, rows[i].wdata, rows[i].strb);
                check(32'(resp), 32'(rows[i].resp));
            end
            rd(rows[i].addr);
            check(rdat, 32'(rows[i].exp));
            check(32'(resp), 32'(rows[i].resp));
        end
        check(32'(cmp1_analog_cfg), 32'({1'b0, DCEC_RESP_SLOW,
            DCEC_HYST_20MV, DCEC_HYST_20MV, 4'hF}));
        wr(`DCEC_OFS_CTRL0, 8'h8E, 4'hF);
        wr(`DCEC_OFS_MODE0, 8'h03, 4'hF);
        wr(`DCEC_OFS_MUX0, 8'h21, 4'hF);
        check(32'(cmp0_analog_cfg), 32'({1'b1, DCEC_RESP_SLOW,
            DCEC_HYST_20MV, DCEC_HYST_10MV, 4'h6}));
        edge_run(0);
        edge_run(1);
        // Second reset in mid-run, with settings left behind
        wr(`DCEC_OFS_CTRL0, 8'h80, 4'hF);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`DCEC_OFS_MODE0, 8'h02);
        rd_chk(`DCEC_OFS_CTRL0, 8'h00);
        chk_o(0, 5'h00);
        wrap_up();
    end
endmodule : dcec_tb_top

`default_nettype wire
